/* File: shared/fwp_regs.svh */
`ifndef FWP_REGS_SVH
`define FWP_REGS_SVH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define FWP_AW            20
`define FWP_SZ_W          21
`define FWP_LEN_W         9
`define FWP_ARRAY_TOP     20'hfffff
`define FWP_ARRAY_SIZE    21'h100000
`define FWP_COARSE_UNIT   21'h010000
`define FWP_FINE_UNIT     21'h001000
`define FWP_FINE_MAX      21'h008000
`define FWP_SECTOR_MASK   20'h00fff
`define FWP_BLOCK_MASK    20'h0ffff
`define FWP_PAGE_OFS_W    8
`define FWP_PAGE_BYTES    9'h100
`define FWP_ERASE_BYTE    8'hff

// ----------------------------------------
// protect-level code points
// ----------------------------------------
`define FWP_BP_NONE       3'h0
`define FWP_BP_STEP       3'h1
`define FWP_BP_FINE_CAP   3'h4
`define FWP_BP_COARSE_ALL 3'h5
`define FWP_BP_ALL_MIN    3'h6

`endif

/* File: shared/fwp_pkg.sv */
`include "fwp_regs.svh"

package fwp_pkg;

    // ----------------------------------------
    // commands handed over by the serial decoder
    // ----------------------------------------
    typedef enum logic [3:0] {
        CMD_NOP          = 4'h0,
        CMD_WRITE_UNLOCK = 4'h1,
        CMD_PAGE_WRITE   = 4'h2,
        CMD_FOUR_K_WIPE  = 4'h3,
        CMD_BLOCK_WIPE   = 4'h4,
        CMD_CHIP_WIPE    = 4'h5,
        CMD_STATUS_WRITE = 4'h6,
        CMD_SLEEP_ENTER  = 4'h7,
        CMD_WAKE_AND_ID  = 4'h8
    } fwp_cmd_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_BUSY  = 2'b01,
        ST_SLEEP = 2'b10
    } fwp_state_e;

    typedef enum logic [1:0] {
        PWR_STANDBY = 2'b00,
        PWR_ACTIVE  = 2'b01,
        PWR_DEEP    = 2'b10
    } fwp_pwr_e;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic                   valid;
        fwp_cmd_e               code;
        logic [`FWP_AW-1:0]     addr;
        logic [`FWP_LEN_W-1:0]  len;
        logic                   aligned;
    } fwp_cmd_s;

    typedef struct packed {
        logic       invert_protection;
        logic       fine_grain_select;
        logic       top_bottom_select;
        logic [2:0] protect_level;
    } fwp_prot_s;

    typedef struct packed {
        logic               empty;
        logic [`FWP_AW-1:0] lo;
        logic [`FWP_AW-1:0] hi;
    } fwp_range_s;

    typedef struct packed {
        fwp_cmd_e               kind;
        logic [`FWP_AW-1:0]     addr;
        logic [`FWP_LEN_W-1:0]  len;
    } fwp_op_s;

endpackage

/* File: core/fwp_gate.sv */
`timescale 1ns/1ps
`include "fwp_regs.svh"

// Overview of operation
// [RQ1] invert clear: 000 none, else edge range
// [RQ2] invert set: exact complement of that range
// [RQ3] program/erase touching protected range is ignored
// [RQ4] host unlocks in own frame before program
// [RQ5] page program up to 256 bytes, one page
// [RQ6] program only clears bits; erase writes ffh
// [RQ7] sector, block and chip erase start cycle
// [RQ8] erase refused without prior write unlock
// [RQ9] busy flag high through every internal cycle
// [RQ10] active while selected or busy, else standby
// [RQ11] deep sleep only on sleep command
// [RQ12] deep sleep left only by wake command
// [RQ13] deep sleep ignores everything but wake
// [RQ14] host polls busy flag before next write
// [RQ15] unlock latch cleared at cycle end, reset
// [RQ16] unaligned write-class frames are ignored
// [RQ17] busy cycle ignores all other commands
// [RQ18] protection decided once, at acceptance
// [RQ19] busy flag and latch drop together
// [RQ20] protection reject returns idle, no busy
module fwp_gate (
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  SYS_RST,
    input  wire logic                  CE,
    // chip select pin
    input  wire logic                  CS_N,
    // decoded command and stored settings
    input  wire fwp_pkg::fwp_cmd_s     CMD,
    input  wire fwp_pkg::fwp_prot_s    PROT,
    // array sequencer handshake
    input  wire logic                  ARR_DONE,
    input  wire logic                  MERGE_REQ,
    input  wire logic [7:0]            MERGE_OLD,
    input  wire logic [7:0]            MERGE_NEW,
    output logic                       ARR_START,
    output fwp_pkg::fwp_op_s           ARR_OP,
    output logic                       MERGE_VALID,
    output logic [7:0]                 MERGE_BYTE,
    // status
    output logic                       CYCLE_IN_PROGRESS_FLAG,
    output logic                       WRITE_UNLOCK_LATCH,
    output logic                       PROT_REJECT,
    output fwp_pkg::fwp_pwr_e          POWER_STATE
);

    // ----------------------------------------
    // protected range decode
    // ----------------------------------------
    function automatic fwp_pkg::fwp_range_s prot_range(input fwp_pkg::fwp_prot_s p);
        logic [`FWP_SZ_W-1:0] sz;
        logic [`FWP_SZ_W-1:0] rest;
        logic                 all;
        logic                 none;
        fwp_pkg::fwp_range_s  r;
        sz   = '0;
        all  = 1'b0;
        none = 1'b0;
        if (p.protect_level == `FWP_BP_NONE) begin
            none = 1'b1;                                                   // [RQ1]
        end else if (p.protect_level >= `FWP_BP_ALL_MIN) begin
            all = 1'b1;
        end else if (!p.fine_grain_select) begin
            if (p.protect_level >= `FWP_BP_COARSE_ALL) begin
                all = 1'b1;
            end else begin
                sz = `FWP_COARSE_UNIT << (p.protect_level - `FWP_BP_STEP); // [RQ1]
            end
        end else if (p.protect_level >= `FWP_BP_FINE_CAP) begin
            sz = `FWP_FINE_MAX;
        end else begin
            sz = `FWP_FINE_UNIT << (p.protect_level - `FWP_BP_STEP);       // [RQ1]
        end
        rest    = `FWP_ARRAY_SIZE - sz;
        r.empty = p.invert_protection ? all : none;                        // [RQ2]
        if (all || none) begin
            r.lo = '0;
            r.hi = `FWP_ARRAY_TOP;
        end else if (p.top_bottom_select ^ p.invert_protection) begin
            // low edge: plain bottom range, or complement of a top range
            r.lo = '0;
            r.hi = p.invert_protection ? rest[`FWP_AW-1:0] - 20'h00001     // [RQ2]
                                       : sz[`FWP_AW-1:0] - 20'h00001;
        end else begin
            r.lo = p.invert_protection ? sz[`FWP_AW-1:0] : rest[`FWP_AW-1:0];
            r.hi = `FWP_ARRAY_TOP;
        end
        return r;
    endfunction

    // ----------------------------------------
    // chip select synchroniser
    // ----------------------------------------
    logic cs_n_meta_q, cs_n_meta_d;
    logic cs_n_sync_q, cs_n_sync_d;

    // pin is asynchronous to CLK, two stages before use
    always_comb begin
        cs_n_meta_d = CS_N;
        cs_n_sync_d = cs_n_meta_q;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cs_n_meta_q <= 1'b1;
            cs_n_sync_q <= 1'b1;
        end else if (CE) begin
            cs_n_meta_q <= cs_n_meta_d;
            cs_n_sync_q <= cs_n_sync_d;
        end
    end

    // ----------------------------------------
    // admission and cycle sequencing
    // ----------------------------------------
    fwp_pkg::fwp_state_e state_q, state_d;
    fwp_pkg::fwp_op_s    op_q, op_d;
    fwp_pkg::fwp_pwr_e   pwr_q, pwr_d;
    fwp_pkg::fwp_range_s prange;
    logic                ulk_q, ulk_d;
    logic                bsy_q, bsy_d;
    logic                start_q, start_d;
    logic                rej_q, rej_d;
    logic [`FWP_AW-1:0]  tgt_lo;
    logic [`FWP_AW-1:0]  tgt_hi;
    logic [`FWP_LEN_W:0] page_end;
    logic                is_array;
    logic                is_write;
    logic                page_ok;
    logic                overlap;

    // target span of the incoming command
    always_comb begin
        prange   = prot_range(PROT);                                       // [RQ18]
        page_end = {1'b0, 1'b0, CMD.addr[`FWP_PAGE_OFS_W-1:0]} + {1'b0, CMD.len};
        page_ok  = (CMD.len != '0) && (page_end <= {1'b0, `FWP_PAGE_BYTES}); // [RQ5]
        tgt_lo   = CMD.addr;
        tgt_hi   = CMD.addr + {{(`FWP_AW-`FWP_LEN_W){1'b0}}, CMD.len} - 20'h00001;
        unique case (CMD.code)
            fwp_pkg::CMD_FOUR_K_WIPE: begin
                tgt_lo = CMD.addr & ~`FWP_SECTOR_MASK;                     // [RQ7]
                tgt_hi = CMD.addr | `FWP_SECTOR_MASK;
            end
            fwp_pkg::CMD_BLOCK_WIPE: begin
                tgt_lo = CMD.addr & ~`FWP_BLOCK_MASK;                      // [RQ7]
                tgt_hi = CMD.addr | `FWP_BLOCK_MASK;
            end
            fwp_pkg::CMD_CHIP_WIPE: begin
                tgt_lo = '0;                                               // [RQ7]
                tgt_hi = `FWP_ARRAY_TOP;
            end
            default: begin
            end
        endcase
        is_array = (CMD.code == fwp_pkg::CMD_PAGE_WRITE) || (CMD.code == fwp_pkg::CMD_FOUR_K_WIPE)
                || (CMD.code == fwp_pkg::CMD_BLOCK_WIPE) || (CMD.code == fwp_pkg::CMD_CHIP_WIPE);
        is_write = is_array || (CMD.code == fwp_pkg::CMD_STATUS_WRITE);
        overlap  = !prange.empty && (tgt_lo <= prange.hi) && (tgt_hi >= prange.lo); // [RQ3]
    end

    // next state; commands arrive as one-cycle strobes from the decoder
    always_comb begin
        state_d = state_q;
        op_d    = op_q;
        ulk_d   = ulk_q;
        start_d = 1'b0;
        rej_d   = 1'b0;
        unique case (state_q)
            fwp_pkg::ST_IDLE: begin
                if (CMD.valid && CMD.code == fwp_pkg::CMD_SLEEP_ENTER) begin
                    state_d = fwp_pkg::ST_SLEEP;                           // [RQ11]
                end else if (CMD.valid && CMD.aligned) begin                // [RQ16]
                    if (CMD.code == fwp_pkg::CMD_WRITE_UNLOCK) begin
                        ulk_d = 1'b1;
                    end else if (is_write && ulk_q) begin                    // [RQ8]
                        if (is_array && overlap) begin
                            rej_d = 1'b1;                                    // [RQ20]
                        end else if (CMD.code != fwp_pkg::CMD_PAGE_WRITE || page_ok) begin
                            state_d = fwp_pkg::ST_BUSY;                      // [RQ9]
                            start_d = 1'b1;
                            op_d    = '{kind: CMD.code, addr: CMD.addr, len: CMD.len};
                        end
                    end
                end
            end
            fwp_pkg::ST_BUSY: begin
                // commands ignored while busy; range decision held in op_q
                if (ARR_DONE) begin                                          // [RQ17]
                    state_d = fwp_pkg::ST_IDLE;
                    ulk_d   = 1'b0;                                          // [RQ15]
                end
            end
            fwp_pkg::ST_SLEEP: begin // [RQ13] only wake leaves
                if (CMD.valid && CMD.code == fwp_pkg::CMD_WAKE_AND_ID) begin
                    state_d = fwp_pkg::ST_IDLE;                              // [RQ12]
                end
            end
            default: begin
                state_d = fwp_pkg::ST_IDLE;
            end
        endcase
        bsy_d = (state_d == fwp_pkg::ST_BUSY);                               // [RQ19]
        if (state_d == fwp_pkg::ST_SLEEP) begin
            pwr_d = fwp_pkg::PWR_DEEP;
        end else if (!cs_n_sync_q || state_d == fwp_pkg::ST_BUSY) begin
            pwr_d = fwp_pkg::PWR_ACTIVE;                                     // [RQ10]
        end else begin
            pwr_d = fwp_pkg::PWR_STANDBY;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_q <= fwp_pkg::ST_IDLE;
            op_q    <= '0;
            ulk_q   <= 1'b0;
            bsy_q   <= 1'b0;
            start_q <= 1'b0;
            rej_q   <= 1'b0;
            pwr_q   <= fwp_pkg::PWR_STANDBY;
        end else if (CE) begin
            state_q <= state_d;
            op_q    <= op_d;
            ulk_q   <= ulk_d;
            bsy_q   <= bsy_d;
            start_q <= start_d;
            rej_q   <= rej_d;
            pwr_q   <= pwr_d;
        end
    end

    // ----------------------------------------
    // array data merge
    // ----------------------------------------
    logic       mval_q, mval_d;
    logic [7:0] mbyte_q, mbyte_d;

    // and-merge makes a program unable to raise any bit
    always_comb begin
        mval_d  = MERGE_REQ && (state_q == fwp_pkg::ST_BUSY)
               && (op_q.kind != fwp_pkg::CMD_STATUS_WRITE);
        mbyte_d = (op_q.kind == fwp_pkg::CMD_PAGE_WRITE) ? (MERGE_OLD & MERGE_NEW) // [RQ6]
                                                         : `FWP_ERASE_BYTE;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mval_q  <= 1'b0;
            mbyte_q <= `FWP_ERASE_BYTE;
        end else if (CE) begin
            mval_q  <= mval_d;
            mbyte_q <= mbyte_d;
        end
    end

    assign ARR_START              = start_q;
    assign ARR_OP                 = op_q;
    assign MERGE_VALID            = mval_q;
    assign MERGE_BYTE             = mbyte_q;
    assign CYCLE_IN_PROGRESS_FLAG = bsy_q;
    assign WRITE_UNLOCK_LATCH     = ulk_q;
    assign PROT_REJECT            = rej_q;
    assign POWER_STATE            = pwr_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    unlock_before_start_a: assert property (ARR_START |-> $past(ulk_q)) // [RQ8]
        else $error("cycle started without write unlock");
    protect_reject_a: assert property (CE && CMD.valid && CMD.aligned && state_q == fwp_pkg::ST_IDLE // [RQ3]
        && ulk_q && is_array && overlap |=> !ARR_START && !CYCLE_IN_PROGRESS_FLAG && PROT_REJECT)
        else $error("protected target was admitted");
    sleep_entry_a: assert property (state_q == fwp_pkg::ST_SLEEP && $past(state_q) != fwp_pkg::ST_SLEEP // [RQ11]
        |-> $past(CMD.valid && CMD.code == fwp_pkg::CMD_SLEEP_ENTER))
        else $error("deep sleep entered without command");
    sleep_hold_a: assert property (CE && state_q == fwp_pkg::ST_SLEEP // [RQ13]
        && !(CMD.valid && CMD.code == fwp_pkg::CMD_WAKE_AND_ID) |=> state_q == fwp_pkg::ST_SLEEP && !ARR_START)
        else $error("deep sleep left or acted without wake");
    cycle_end_a: assert property (CE && state_q == fwp_pkg::ST_BUSY && ARR_DONE // [RQ19]
        |=> !WRITE_UNLOCK_LATCH && !CYCLE_IN_PROGRESS_FLAG)
        else $error("latch and busy flag did not drop together");
    busy_hold_a: assert property (CE && state_q == fwp_pkg::ST_BUSY && !ARR_DONE // [RQ9]
        |=> CYCLE_IN_PROGRESS_FLAG && !ARR_START && $stable(ARR_OP))
        else $error("busy cycle disturbed");
    unaligned_drop_a: assert property (CE && CMD.valid && !CMD.aligned && state_q == fwp_pkg::ST_IDLE // [RQ16]
        |=> $stable(WRITE_UNLOCK_LATCH) && !ARR_START)
        else $error("unaligned frame took effect");
    erase_fill_a: assert property (MERGE_VALID && ARR_OP.kind != fwp_pkg::CMD_PAGE_WRITE // [RQ6]
        |-> MERGE_BYTE == `FWP_ERASE_BYTE)
        else $error("erase did not write all ones");
    no_raise_a: assert property (CE && MERGE_REQ && state_q == fwp_pkg::ST_BUSY // [RQ6]
        && op_q.kind == fwp_pkg::CMD_PAGE_WRITE |=> (MERGE_BYTE & ~$past(MERGE_OLD)) == 8'h00)
        else $error("program raised a bit");
    standby_a: assert property (CE && state_q == fwp_pkg::ST_IDLE && cs_n_sync_q // [RQ10]
        && !CMD.valid |=> POWER_STATE == fwp_pkg::PWR_STANDBY)
        else $error("idle deselected part not in standby");

endmodule

/* File: testbench/fwp_seq_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// array sequencer stand-in
// ----------------------------------------
module fwp_seq_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // cycle handshake
    input  wire logic       start,
    input  wire logic [7:0] dly,
    output logic            done = 1'b0,
    // byte merge request
    output logic            mreq = 1'b0,
    output logic [7:0]      mold = 8'h0f,
    output logic [7:0]      mnew = 8'hc3
);
    logic [7:0] cnt_q = 8'h00;

    // one merge mid-cycle, done at the end; dly picks a prompt or slow answer
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (start) begin
            cnt_q <= dly;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
        mreq <= !rst && cnt_q == 8'h04;
        done <= !rst && cnt_q == 8'h01;
        // data flips together with the request so a stale byte never passes
        mold <= (cnt_q == 8'h04) ? 8'hf0 : 8'h0f;
        mnew <= (cnt_q == 8'h04) ? 8'h3c : 8'hc3;
    end
endmodule

/* File: testbench/fwp_gate_tb_top.sv */
`timescale 1ns/1ps

module fwp_gate_tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                cs_n = 1'b1;
    logic                done, mreq, start, mvalid, flag, latch, rej;
    logic [7:0]          mold, mnew, mbyte;
    logic [7:0]          mb = 8'h00;
    logic [7:0]          dly = 8'd6;
    fwp_pkg::fwp_cmd_s   cmd = '0;
    fwp_pkg::fwp_prot_s  prot = '0;
    fwp_pkg::fwp_op_s    op;
    fwp_pkg::fwp_pwr_e   pwr;
    int                  bad_count = 0;
    int                  compares = 0;

    // ----------------------------------------
    // design and partner
    // ----------------------------------------
    fwp_gate dut (
        .CLK(clk), .SYS_RST(rst), .CE(1'b1), .CS_N(cs_n), .CMD(cmd), .PROT(prot),
        .ARR_DONE(done), .MERGE_REQ(mreq), .MERGE_OLD(mold), .MERGE_NEW(mnew),
        .ARR_START(start), .ARR_OP(op), .MERGE_VALID(mvalid), .MERGE_BYTE(mbyte),
        .CYCLE_IN_PROGRESS_FLAG(flag), .WRITE_UNLOCK_LATCH(latch),
        .PROT_REJECT(rej), .POWER_STATE(pwr)
    );
    fwp_seq_model seq (
        .clk(clk), .rst(rst), .start(start), .dly(dly),
        .done(done), .mreq(mreq), .mold(mold), .mnew(mnew)
    );

    // clock and merge capture; pre-edge value read, so no race
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (mvalid === 1'b1) mb <= mbyte;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick();
        @(negedge clk);
    endtask

    task automatic chk_bit(logic g, logic e, string m);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task automatic chk_val(logic [7:0] g, logic [7:0] e, string m);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t %s got %h", $time, m, g);
        end
    endtask

    // keep holds valid so a following command lands back to back
    task automatic send(fwp_pkg::fwp_cmd_e c, logic [19:0] a = 0, logic [8:0] l = 1,
                        logic al = 1, bit keep = 0);
        cmd = '{1'b1, c, a, l, al};
        @(negedge clk);
        if (!keep) cmd.valid = 1'b0;
    endtask

    task automatic ucmd(fwp_pkg::fwp_cmd_e c, logic [19:0] a, logic [8:0] l = 1);
        tick();
        send(fwp_pkg::CMD_WRITE_UNLOCK, 0, 1, 1, 1);
        send(c, a, l);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 200 && flag !== 1'b0; i++) @(negedge clk);
        chk_bit(flag, 1'b0, "cycle never ended");
        chk_bit(latch, 1'b0, "latch not cleared with flag");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk_val(mbyte, 8'hff, "reset merge byte");
        chk_bit(latch, 1'b0, "reset latch");
        chk_val(8'(pwr), 8'(fwp_pkg::PWR_STANDBY), "reset power");
        tick();
        send(fwp_pkg::CMD_BLOCK_WIPE, 0);
        chk_bit(start, 1'b0, "wipe without unlock");
    endtask

    task automatic t_power();
        cs_n = 1'b0;
        repeat (4) tick();
        chk_val(8'(pwr), 8'(fwp_pkg::PWR_ACTIVE), "selected not active");
        cs_n = 1'b1;
        repeat (4) tick();
        chk_val(8'(pwr), 8'(fwp_pkg::PWR_STANDBY), "no standby");
    endtask

    task automatic t_page();
        tick();
        send(fwp_pkg::CMD_WRITE_UNLOCK, 0, 1, 0);
        chk_bit(latch, 1'b0, "unaligned unlock taken");
        ucmd(fwp_pkg::CMD_PAGE_WRITE, 20'h000f0, 9'h020);
        chk_bit(start, 1'b0, "page crossing taken");
        tick();
        send(fwp_pkg::CMD_PAGE_WRITE, 20'h00100, 9'h100, 0);
        chk_bit(start, 1'b0, "unaligned page taken");
        tick();
        mb = 8'h00;
        send(fwp_pkg::CMD_PAGE_WRITE, 20'h00100, 9'h100);
        chk_bit(start, 1'b1, "full page refused");
        chk_bit(op.addr == 20'h00100 && op.len == 9'h100, 1'b1, "page op fields");
        chk_bit(flag, 1'b1, "flag low in cycle");
        chk_val(8'(pwr), 8'(fwp_pkg::PWR_ACTIVE), "busy not active");
        tick();
        send(fwp_pkg::CMD_FOUR_K_WIPE, 20'h80000);
        chk_val(8'(op.kind), 8'(fwp_pkg::CMD_PAGE_WRITE), "busy took command");
        chk_bit(latch, 1'b1, "latch dropped early");
        wait_idle();
        chk_val(mb, 8'h30, "program set bits");
    endtask

    task automatic t_wipe();
        fwp_pkg::fwp_cmd_e k[3] = '{fwp_pkg::CMD_FOUR_K_WIPE, fwp_pkg::CMD_BLOCK_WIPE,
                                    fwp_pkg::CMD_CHIP_WIPE};
        dly = 8'd40;
        foreach (k[i]) begin
            mb = 8'h00;
            ucmd(k[i], 20'h12345);
            chk_bit(start, 1'b1, "wipe refused");
            chk_val(8'(op.kind), 8'(k[i]), "wipe kind");
            chk_bit(op.addr == 20'h12345, 1'b1, "wipe address");
            wait_idle();
            chk_val(mb, 8'hff, "wipe byte");
        end
        dly = 8'd6;
        // status write runs a cycle but never merges array data
        mb = 8'h00;
        ucmd(fwp_pkg::CMD_STATUS_WRITE, 0);
        chk_val(8'(op.kind), 8'(fwp_pkg::CMD_STATUS_WRITE), "status write refused");
        chk_bit(flag, 1'b1, "flag low in status write");
        wait_idle();
        chk_val(mb, 8'h00, "status write merged");
    endtask

    task automatic t_sleep();
        tick();
        send(fwp_pkg::CMD_SLEEP_ENTER);
        repeat (2) tick();
        chk_val(8'(pwr), 8'(fwp_pkg::PWR_DEEP), "no deep sleep");
        ucmd(fwp_pkg::CMD_CHIP_WIPE, 0);
        chk_bit(start, 1'b0, "wipe in sleep");
        chk_bit(latch, 1'b0, "unlock in sleep");
        chk_val(8'(pwr), 8'(fwp_pkg::PWR_DEEP), "left sleep");
        tick();
        send(fwp_pkg::CMD_WAKE_AND_ID);
        repeat (2) tick();
        chk_val(8'(pwr), 8'(fwp_pkg::PWR_STANDBY), "no wake");
    endtask

    task automatic t_prot();
        logic [5:0]  pc[16] = '{6'h00, 6'h01, 6'h01, 6'h0c, 6'h0c, 6'h11, 6'h11, 6'h1d,
                                6'h1d, 6'h20, 6'h21, 6'h21, 6'h25, 6'h39, 6'h39, 6'h26};
        logic [19:0] pa[16] = '{20'hfffff, 20'hf0000, 20'hef000, 20'h7f000, 20'h80000,
                                20'hff000, 20'hfe000, 20'h07000, 20'h08000, 20'h00000,
                                20'hf0000, 20'hef000, 20'h00000, 20'h00000, 20'h01000,
                                20'h00000};
        logic        pr[16] = '{0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 0, 1, 0};
        foreach (pc[i]) begin
            prot = fwp_pkg::fwp_prot_s'(pc[i]);
            ucmd(fwp_pkg::CMD_FOUR_K_WIPE, pa[i]);
            chk_bit(rej, pr[i], "protect decision");
            chk_bit(flag, !pr[i], "flag after decision");
            if (!pr[i]) wait_idle();
        end
    endtask

    // reset in the middle of a cycle must drop busy and latch
    task automatic t_midreset();
        ucmd(fwp_pkg::CMD_CHIP_WIPE, 0);
        chk_bit(flag, 1'b1, "chip wipe refused");
        rst = 1'b1;
        repeat (2) tick();
        rst = 1'b0;
        chk_bit(flag, 1'b0, "reset left busy");
        chk_bit(latch, 1'b0, "reset left latch");
        chk_val(8'(pwr), 8'(fwp_pkg::PWR_STANDBY), "power after reset");
        ucmd(fwp_pkg::CMD_FOUR_K_WIPE, 20'h40000);
        chk_bit(start, 1'b1, "no start after reset");
        wait_idle();
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        bad_count++;
        summarize();
    end

    // main sequence
    initial begin
        repeat (8) tick();
        rst = 1'b0;
        t_reset();
        t_power();
        t_page();
        t_wipe();
        t_sleep();
        t_prot();
        t_midreset();
        summarize();
    end
endmodule
